// >>> rtl/pcd_pin_change.sv
// pin change detector: per-pin edge flags, summary, interrupt and wake request
// assumes the system clock keeps running for this block during sleep
`timescale 1ns/1ns
module pcd_pin_change
(
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          cyc_i,
	input  wire logic                          stb_i,
	input  wire logic                          we_i,
	input  wire logic [pcd_pkg::ADR_W-1:0]     adr_i,
	input  wire logic [pcd_pkg::BUS_W-1:0]     dat_i,
	input  wire logic [pcd_pkg::SEL_W-1:0]     sel_i,
	output      logic [pcd_pkg::BUS_W-1:0]     dat_o,
	output      logic                          ack_o,
	input  wire logic [pcd_pkg::DATA_W-1:0]    porta_pins_i,
	input  wire logic [pcd_pkg::DATA_W-1:0]    portb_pins_i,
	input  wire logic                          sleep_i,
	output      logic                          irq_o,
	output      logic                          wake_o,
	output      logic                          change_irq_summary_o
);

	// --------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------
	function automatic pcd_pkg::pcd_dec_s pcd_decode(input logic [pcd_pkg::ADR_W-1:0] adr);
		pcd_pkg::pcd_dec_s d;
		d.field = pcd_pkg::PCD_FLD_NONE;
		d.port  = 1'b0;
		if (adr[pcd_pkg::ADR_W-1:pcd_pkg::DEC_W] == '0)
		begin
			unique case (adr[pcd_pkg::DEC_W-1:0])
				pcd_pkg::OFF_A_RISE: d.field = pcd_pkg::PCD_FLD_RISE;
				pcd_pkg::OFF_A_FALL: d.field = pcd_pkg::PCD_FLD_FALL;
				pcd_pkg::OFF_A_FLAG: d.field = pcd_pkg::PCD_FLD_FLAG;
				pcd_pkg::OFF_B_RISE:
				begin
					d.field = pcd_pkg::PCD_FLD_RISE;
					d.port  = 1'b1;
				end
				pcd_pkg::OFF_B_FALL:
				begin
					d.field = pcd_pkg::PCD_FLD_FALL;
					d.port  = 1'b1;
				end
				pcd_pkg::OFF_B_FLAG:
				begin
					d.field = pcd_pkg::PCD_FLD_FLAG;
					d.port  = 1'b1;
				end
				pcd_pkg::OFF_IRQ_EN: d.field = pcd_pkg::PCD_FLD_PIE;
				pcd_pkg::OFF_IRQ_REQ: d.field = pcd_pkg::PCD_FLD_PIR;
				default:             d.field = pcd_pkg::PCD_FLD_NONE;
			endcase
		end
		return d;
	endfunction : pcd_decode

	localparam logic [pcd_pkg::DATA_W-1:0] PORT_MASK [pcd_pkg::NUM_PORTS] =
		'{pcd_pkg::PORTA_MASK, pcd_pkg::PORTB_MASK};

	pcd_pkg::pcd_port_s                cfg_reg   [pcd_pkg::NUM_PORTS];
	logic [pcd_pkg::DATA_W-1:0]        pins      [pcd_pkg::NUM_PORTS];
	logic [pcd_pkg::DATA_W-1:0]        meta_reg  [pcd_pkg::NUM_PORTS];
	logic [pcd_pkg::DATA_W-1:0]        sync_reg  [pcd_pkg::NUM_PORTS];
	logic [pcd_pkg::DATA_W-1:0]        prev_reg  [pcd_pkg::NUM_PORTS];
	logic [pcd_pkg::DATA_W-1:0]        edge_hit  [pcd_pkg::NUM_PORTS];
	logic [pcd_pkg::DATA_W-1:0]        rise_hit  [pcd_pkg::NUM_PORTS];
	logic [pcd_pkg::DATA_W-1:0]        fall_hit  [pcd_pkg::NUM_PORTS];
	logic [pcd_pkg::NUM_PORTS-1:0]     port_any;
	logic                              chg_ie_reg;
	logic                              ack_reg;
	logic                              req;
	logic                              wr_low;
	pcd_pkg::pcd_dec_s                 dec;
	logic [pcd_pkg::DATA_W-1:0]        rd_next;

	assign pins[pcd_pkg::PORT_A] = porta_pins_i;
	assign pins[pcd_pkg::PORT_B] = portb_pins_i;

	assign req    = cyc_i && stb_i && !ack_reg;
	assign wr_low = req && we_i && sel_i[0];
	assign dec    = pcd_decode(adr_i);

	// --------------------------------------------------------------
	// per-port synchroniser, edge detection and registers
	// --------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < pcd_pkg::NUM_PORTS; gp++)
		begin : g_port
			logic sel_port;
			assign sel_port = (dec.port == 1'(gp));

			// first stage feeds only the second; third keeps the previous sample
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					meta_reg[gp] <= pcd_pkg::REG_RST;
					sync_reg[gp] <= pcd_pkg::REG_RST;
					prev_reg[gp] <= pcd_pkg::REG_RST;
				end
				else
				begin
					meta_reg[gp] <= pins[gp];
					sync_reg[gp] <= meta_reg[gp];
					prev_reg[gp] <= sync_reg[gp];
				end
			end

			// independent rise and fall terms per pin, either or both
			assign rise_hit[gp] = sync_reg[gp] & ~prev_reg[gp] & cfg_reg[gp].rise;
			assign fall_hit[gp] = ~sync_reg[gp] & prev_reg[gp] & cfg_reg[gp].fall;
			assign edge_hit[gp] = (rise_hit[gp] | fall_hit[gp]) & PORT_MASK[gp];

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					cfg_reg[gp].rise <= pcd_pkg::REG_RST;
					cfg_reg[gp].fall <= pcd_pkg::REG_RST;
				end
				else if (wr_low && sel_port)
				begin
					if (dec.field == pcd_pkg::PCD_FLD_RISE)
						cfg_reg[gp].rise <= dat_i[pcd_pkg::DATA_W-1:0] & PORT_MASK[gp];
					if (dec.field == pcd_pkg::PCD_FLD_FALL)
						cfg_reg[gp].fall <= dat_i[pcd_pkg::DATA_W-1:0] & PORT_MASK[gp];
				end
			end

			// a new edge beats a clearing write in the same cycle
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					cfg_reg[gp].flags <= pcd_pkg::REG_RST;
				else if (wr_low && sel_port && dec.field == pcd_pkg::PCD_FLD_FLAG)
					cfg_reg[gp].flags <= (dat_i[pcd_pkg::DATA_W-1:0] & PORT_MASK[gp]) | edge_hit[gp];
				else
					cfg_reg[gp].flags <= cfg_reg[gp].flags | edge_hit[gp];
			end

			assign port_any[gp] = |cfg_reg[gp].flags;
		end
	endgenerate

	// --------------------------------------------------------------
	// global enable, summary, interrupt and wake
	// --------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			chg_ie_reg <= 1'b0;
		else if (wr_low && dec.field == pcd_pkg::PCD_FLD_PIE)
			chg_ie_reg <= dat_i[pcd_pkg::CHG_IE_BIT];
	end

	// summary is derived, so writes to its register have no effect
	assign change_irq_summary_o = |port_any;
	assign irq_o                = change_irq_summary_o && chg_ie_reg;
	// clock is assumed to run in sleep, so edges are caught by the same detector
	assign wake_o               = sleep_i && irq_o;

	// --------------------------------------------------------------
	// wishbone read path and acknowledge
	// --------------------------------------------------------------
	always_comb
	begin
		rd_next = pcd_pkg::REG_RST;
		unique case (dec.field)
			pcd_pkg::PCD_FLD_RISE: rd_next = cfg_reg[dec.port].rise;
			pcd_pkg::PCD_FLD_FALL: rd_next = cfg_reg[dec.port].fall;
			pcd_pkg::PCD_FLD_FLAG: rd_next = cfg_reg[dec.port].flags;
			pcd_pkg::PCD_FLD_PIE:  rd_next[pcd_pkg::CHG_IE_BIT] = chg_ie_reg;
			pcd_pkg::PCD_FLD_PIR:  rd_next[pcd_pkg::CHG_IF_BIT] = change_irq_summary_o;
			pcd_pkg::PCD_FLD_NONE: rd_next = pcd_pkg::REG_RST;
			default:               rd_next = pcd_pkg::REG_RST;
		endcase
	end

	// every access, mapped or not, answers one cycle after it is taken
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= req;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= '0;
		else if (req && !we_i)
			dat_o <= {{(pcd_pkg::BUS_W-pcd_pkg::DATA_W){1'b0}}, rd_next};
	end

	assign ack_o = ack_reg;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_edge_sets_flag: assert property (
		(edge_hit[pcd_pkg::PORT_A] != '0)
		|=> ((cfg_reg[pcd_pkg::PORT_A].flags & $past(edge_hit[pcd_pkg::PORT_A]))
		     == $past(edge_hit[pcd_pkg::PORT_A])))
		else $error("enabled edge on port a did not set its flag");

	a_write_set_wins: assert property (
		(wr_low && dec.field == pcd_pkg::PCD_FLD_FLAG && !dec.port && edge_hit[pcd_pkg::PORT_A] != '0)
		|=> ((cfg_reg[pcd_pkg::PORT_A].flags & $past(edge_hit[pcd_pkg::PORT_A]))
		     == $past(edge_hit[pcd_pkg::PORT_A])))
		else $error("edge lost during flag write");

	a_flag_zero_clear: assert property (
		(wr_low && dec.field == pcd_pkg::PCD_FLD_FLAG && !dec.port
		 && dat_i[pcd_pkg::DATA_W-1:0] == '0 && edge_hit[pcd_pkg::PORT_A] == '0)
		|=> cfg_reg[pcd_pkg::PORT_A].flags == '0)
		else $error("zero write did not clear port a flags");

	a_no_edge_stable: assert property (
		(!(wr_low && dec.field == pcd_pkg::PCD_FLD_FLAG) && edge_hit[pcd_pkg::PORT_B] == '0)
		|=> $stable(cfg_reg[pcd_pkg::PORT_B].flags))
		else $error("port b flag changed without edge or write");

	a_rise_needs_enable: assert property (
		((sync_reg[pcd_pkg::PORT_A] & ~prev_reg[pcd_pkg::PORT_A] & ~cfg_reg[pcd_pkg::PORT_A].rise
		  & edge_hit[pcd_pkg::PORT_A]) == '0)
		&& ((sync_reg[pcd_pkg::PORT_B] & ~prev_reg[pcd_pkg::PORT_B] & ~cfg_reg[pcd_pkg::PORT_B].rise
		  & edge_hit[pcd_pkg::PORT_B]) == '0))
		else $error("rise seen on a pin without rise enable");

	a_irq_gated_ie: assert property (
		irq_o |-> chg_ie_reg && change_irq_summary_o)
		else $error("interrupt without global enable");

	a_flags_no_ie: assert property (
		(!chg_ie_reg && edge_hit[pcd_pkg::PORT_A] != '0 && !wr_low)
		|=> change_irq_summary_o && !irq_o)
		else $error("flag not set or request raised with enable clear");

	a_summary_is_or: assert property (
		change_irq_summary_o == ((cfg_reg[pcd_pkg::PORT_A].flags | cfg_reg[pcd_pkg::PORT_B].flags) != '0))
		else $error("summary does not follow pin flags");

	a_unimpl_bits_zero: assert property (
		((cfg_reg[pcd_pkg::PORT_A].flags | cfg_reg[pcd_pkg::PORT_A].rise) & ~pcd_pkg::PORTA_MASK) == '0
		&& ((cfg_reg[pcd_pkg::PORT_B].flags | cfg_reg[pcd_pkg::PORT_B].fall) & ~pcd_pkg::PORTB_MASK) == '0)
		else $error("unimplemented bit is set");

	a_wake_on_change: assert property (
		(sleep_i && chg_ie_reg && change_irq_summary_o) |-> wake_o)
		else $error("no wake for enabled change in sleep");

	a_sync_delay: assert property (
		(!$past(rst_i) && !$past(rst_i, 2))
		|-> (sync_reg[pcd_pkg::PORT_A] == $past(porta_pins_i, 2)
		     && sync_reg[pcd_pkg::PORT_B] == $past(portb_pins_i, 2)
		     && prev_reg[pcd_pkg::PORT_A] == $past(sync_reg[pcd_pkg::PORT_A])
		     && prev_reg[pcd_pkg::PORT_B] == $past(sync_reg[pcd_pkg::PORT_B])))
		else $error("previous sample does not trail synchronised sample");

	a_ack_one_cycle: assert property (
		ack_o |=> !ack_o)
		else $error("acknowledge held longer than one cycle");

	a_edge_flag_b: assert property (
		(edge_hit[pcd_pkg::PORT_B] != '0)
		|=> ((cfg_reg[pcd_pkg::PORT_B].flags & $past(edge_hit[pcd_pkg::PORT_B]))
		     == $past(edge_hit[pcd_pkg::PORT_B])))
		else $error("enabled edge on port b did not set its flag");

	a_zero_clear_b: assert property (
		(wr_low && dec.field == pcd_pkg::PCD_FLD_FLAG && dec.port
		 && dat_i[pcd_pkg::DATA_W-1:0] == '0 && edge_hit[pcd_pkg::PORT_B] == '0)
		|=> cfg_reg[pcd_pkg::PORT_B].flags == '0)
		else $error("zero write did not clear port b flags");

	a_stable_flags_a: assert property (
		(!(wr_low && dec.field == pcd_pkg::PCD_FLD_FLAG) && edge_hit[pcd_pkg::PORT_A] == '0)
		|=> $stable(cfg_reg[pcd_pkg::PORT_A].flags))
		else $error("port a flag changed without edge or write");

	a_fall_needs_enable: assert property (
		((~sync_reg[pcd_pkg::PORT_A] & prev_reg[pcd_pkg::PORT_A] & ~cfg_reg[pcd_pkg::PORT_A].fall
		  & edge_hit[pcd_pkg::PORT_A]) == '0)
		&& ((~sync_reg[pcd_pkg::PORT_B] & prev_reg[pcd_pkg::PORT_B] & ~cfg_reg[pcd_pkg::PORT_B].fall
		  & edge_hit[pcd_pkg::PORT_B]) == '0))
		else $error("fall seen on a pin without fall enable");

	a_both_edges: assert property (
		(((sync_reg[pcd_pkg::PORT_A] ^ prev_reg[pcd_pkg::PORT_A]) ^ edge_hit[pcd_pkg::PORT_A])
		 & cfg_reg[pcd_pkg::PORT_A].rise & cfg_reg[pcd_pkg::PORT_A].fall & pcd_pkg::PORTA_MASK) == '0)
		else $error("pin with both enables missed a change");

	a_enable_write: assert property (
		(wr_low && dec.field == pcd_pkg::PCD_FLD_PIE)
		|=> chg_ie_reg == $past(dat_i[pcd_pkg::CHG_IE_BIT]))
		else $error("global change enable not written");

	a_summary_read_only: assert property (
		(wr_low && dec.field == pcd_pkg::PCD_FLD_PIR && edge_hit[pcd_pkg::PORT_A] == '0
		 && edge_hit[pcd_pkg::PORT_B] == '0)
		|=> $stable(change_irq_summary_o))
		else $error("write to summary register changed the summary");

	a_unmapped_read_zero: assert property (
		(req && !we_i && dec.field == pcd_pkg::PCD_FLD_NONE) |=> dat_o == '0)
		else $error("unmapped read returned nonzero data");

	a_ack_after_req: assert property (
		!$past(rst_i) |-> ack_o == $past(req))
		else $error("acknowledge does not follow a taken request");

	a_read_data_hold: assert property (
		(!$past(rst_i) && !$past(req && !we_i)) |-> $stable(dat_o))
		else $error("read data changed without a read");

	a_irq_on_flag: assert property (
		(chg_ie_reg && change_irq_summary_o) |-> irq_o)
		else $error("enabled flag raised no interrupt request");

	a_no_irq_disabled: assert property (
		!chg_ie_reg |-> !irq_o)
		else $error("interrupt request with global enable clear");

	a_wake_needs_sleep: assert property (
		wake_o |-> sleep_i && irq_o)
		else $error("wake request outside sleep");

	a_rise_write_a: assert property (
		(wr_low && dec.field == pcd_pkg::PCD_FLD_RISE && !dec.port)
		|=> cfg_reg[pcd_pkg::PORT_A].rise == ($past(dat_i[pcd_pkg::DATA_W-1:0]) & pcd_pkg::PORTA_MASK))
		else $error("port a rise enable write not stored");

	a_fall_write_b: assert property (
		(wr_low && dec.field == pcd_pkg::PCD_FLD_FALL && dec.port)
		|=> cfg_reg[pcd_pkg::PORT_B].fall == ($past(dat_i[pcd_pkg::DATA_W-1:0]) & pcd_pkg::PORTB_MASK))
		else $error("port b fall enable write not stored");

endmodule : pcd_pin_change

// >>> rtl/pcd_pkg.sv
// constants, field layouts and carrier types of the pin change detector
// assumes a classic wishbone slave with 32-bit data, 8-bit registers in the low lane
package pcd_pkg;

	localparam int          DATA_W      = 8;
	localparam int          BUS_W       = 32;
	localparam int          SEL_W       = 4;
	localparam int          ADR_W       = 32;
	localparam int          DEC_W       = 5;
	localparam int          NUM_PORTS   = 2;
	localparam int          PORT_A      = 0;
	localparam int          PORT_B      = 1;

	localparam logic [7:0]  PORTA_MASK  = 8'h3f;
	localparam logic [7:0]  PORTB_MASK  = 8'hf0;
	localparam logic [7:0]  REG_RST     = 8'h00;

	// --------------------------------------------------------------
	// register byte offsets
	// --------------------------------------------------------------
	localparam logic [4:0]  OFF_A_RISE  = 5'h00;
	localparam logic [4:0]  OFF_A_FALL  = 5'h04;
	localparam logic [4:0]  OFF_A_FLAG  = 5'h08;
	localparam logic [4:0]  OFF_B_RISE  = 5'h0c;
	localparam logic [4:0]  OFF_B_FALL  = 5'h10;
	localparam logic [4:0]  OFF_B_FLAG  = 5'h14;
	localparam logic [4:0]  OFF_IRQ_EN  = 5'h18;
	localparam logic [4:0]  OFF_IRQ_REQ = 5'h1c;

	localparam int          CHG_IE_BIT  = 4;
	localparam int          CHG_IF_BIT  = 4;

	typedef enum logic [2:0] {
		PCD_FLD_RISE,
		PCD_FLD_FALL,
		PCD_FLD_FLAG,
		PCD_FLD_PIE,
		PCD_FLD_PIR,
		PCD_FLD_NONE
	} pcd_field_e;

	typedef struct packed {
		pcd_field_e field;
		logic       port;
	} pcd_dec_s;

	typedef struct packed {
		logic [7:0] rise;
		logic [7:0] fall;
		logic [7:0] flags;
	} pcd_port_s;

endpackage : pcd_pkg

// >>> test/pcd_pin_model.sv
// far-side model: external port pins and the cpu sleep/wake handshake
// assumes the bench sets pin levels and the sleep request just after clock edges
`timescale 1ns/1ns
module pcd_pin_model
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] a_lvl_i,
	input  wire logic [7:0] b_lvl_i,
	input  wire logic       sleep_req_i,
	input  wire logic       wake_i,
	output      logic [7:0] porta_pins_o,
	output      logic [7:0] portb_pins_o,
	output      logic       sleep_o,
	output      logic       woke_o
);
	// push-pull drivers outside, so the pins always show a real level
	assign porta_pins_o = a_lvl_i;
	assign portb_pins_o = b_lvl_i;
	// cpu leaves sleep on the first wake request, stays awake until asked again
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !sleep_req_i)
			woke_o <= 1'b0;
		else if (wake_i)
			woke_o <= 1'b1;
	end
	assign sleep_o = sleep_req_i & ~woke_o;
endmodule : pcd_pin_model

// >>> test/tb_top.sv
// self-checking bench of the pin change detector
// assumes pcd_pkg and the pin model are compiled first
`timescale 1ns/1ns
module tb_top;
	logic        clk_i, rst_i, cyc, stb, we, ack_o, irq_o, wake_o, summ_o, sleep, woke, sleep_req, ie;
	logic [31:0] adr, dat, dat_o;
	logic [7:0]  a_lvl, b_lvl, pa, pb, q, r, oa, ob, ea, eb, ra, fa, rb, fb;
	logic [4:0]  offs [6];
	logic [7:0]  msks [6];
	int          fails, check_count, seed, n;

	pcd_pin_change uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.dat_i(dat), .sel_i(4'hf), .dat_o(dat_o), .ack_o(ack_o), .porta_pins_i(pa), .portb_pins_i(pb),
		.sleep_i(sleep), .irq_o(irq_o), .wake_o(wake_o), .change_irq_summary_o(summ_o));
	pcd_pin_model far (.clk_i(clk_i), .rst_i(rst_i), .a_lvl_i(a_lvl), .b_lvl_i(b_lvl), .sleep_req_i(sleep_req),
		.wake_i(wake_o), .porta_pins_o(pa), .portb_pins_o(pb), .sleep_o(sleep), .woke_o(woke));

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// bus, compare and closing tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// ack and data are read in the active region, before the edge's updates land; only the watchdog ends a wait
	task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] rd);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= {24'h0, d};
		do
			@(posedge clk_i);
		while (ack_o !== 1'b1);
		rd = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] x;
		wb(1'b1, {27'h0, a}, d, x);
	endtask : wr

	task automatic rdr(input logic [4:0] a, output logic [7:0] d);
		wb(1'b0, {27'h0, a}, 8'h00, d);
	endtask : rdr

	function automatic logic [7:0] edges(input logic [7:0] o, nw, re, fe, m);
		return m & ((re & ~o & nw) | (fe & o & ~nw));
	endfunction : edges

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	initial
	begin
		repeat (20000) @(posedge clk_i);
		fails++;
		$display("watchdog expired");
		report_and_stop();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 32'hf6bf;
		fails = 0;
		check_count = 0;
		{cyc, stb, we, sleep_req} = 4'h0;
		adr = 32'h0;
		dat = 32'h0;
		a_lvl = 8'h00;
		b_lvl = 8'h00;
		rst_i = 1'b1;
		offs = '{pcd_pkg::OFF_A_RISE, pcd_pkg::OFF_A_FALL, pcd_pkg::OFF_B_RISE, pcd_pkg::OFF_B_FALL,
			pcd_pkg::OFF_IRQ_EN, pcd_pkg::OFF_IRQ_REQ};
		msks = '{pcd_pkg::PORTA_MASK, pcd_pkg::PORTA_MASK, pcd_pkg::PORTB_MASK, pcd_pkg::PORTB_MASK, 8'h10, 8'h00};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		// 0x20 lies outside the map and must read zero
		for (int i = 0; i <= 32; i += 4)
		begin
			wb(1'b0, 32'(i), 8'h00, q);
			chk("reset value", q, 8'h00);
		end
		for (int i = 0; i < 6; i++)
		begin
			wr(offs[i], 8'hff);
			rdr(offs[i], q);
			chk("implemented bits", q, msks[i]);
			wr(offs[i], 8'h00);
		end
		$display("test registers done");
		// random enables and pin levels, unimplemented pins toggle too
		repeat (40)
		begin
			ra = 8'($random(seed));
			fa = 8'($random(seed));
			rb = 8'($random(seed));
			fb = 8'($random(seed));
			q = 8'($random(seed));
			ie = q[0];
			wr(pcd_pkg::OFF_A_RISE, ra);
			wr(pcd_pkg::OFF_A_FALL, fa);
			wr(pcd_pkg::OFF_B_RISE, rb);
			wr(pcd_pkg::OFF_B_FALL, fb);
			wr(pcd_pkg::OFF_IRQ_EN, {3'h0, ie, 4'h0});
			wr(pcd_pkg::OFF_A_FLAG, 8'h00);
			wr(pcd_pkg::OFF_B_FLAG, 8'h00);
			oa = a_lvl;
			ob = b_lvl;
			a_lvl <= 8'($random(seed));
			b_lvl <= 8'($random(seed));
			repeat (5) @(posedge clk_i);
			ea = edges(oa, a_lvl, ra, fa, pcd_pkg::PORTA_MASK);
			eb = edges(ob, b_lvl, rb, fb, pcd_pkg::PORTB_MASK);
			rdr(pcd_pkg::OFF_A_FLAG, q);
			chk("port a flags", q, ea);
			rdr(pcd_pkg::OFF_B_FLAG, q);
			chk("port b flags", q, eb);
			rdr(pcd_pkg::OFF_IRQ_REQ, q);
			chk("summary", q, {3'h0, |(ea | eb), 4'h0});
			chk("irq", {7'h0, irq_o}, {7'h0, ie & |(ea | eb)});
			chk("summary pin", {7'h0, summ_o}, {7'h0, |(ea | eb)});
			chk("wake while awake", {7'h0, wake_o}, 8'h00);
		end
		$display("test random edges done");
		wr(pcd_pkg::OFF_A_RISE, 8'h3f);
		wr(pcd_pkg::OFF_A_FALL, 8'h3f);
		wr(pcd_pkg::OFF_A_FLAG, 8'h00);
		// edge lands on the very edge that takes the clearing write
		@(posedge clk_i);
		a_lvl <= a_lvl ^ 8'h02;
		@(posedge clk_i);
		wr(pcd_pkg::OFF_A_FLAG, 8'h00);
		rdr(pcd_pkg::OFF_A_FLAG, q);
		chk("edge during clear", q, 8'h02);
		a_lvl <= a_lvl ^ 8'h04;
		repeat (5) @(posedge clk_i);
		rdr(pcd_pkg::OFF_A_FLAG, r);
		wr(pcd_pkg::OFF_A_FLAG, r & ~q);
		rdr(pcd_pkg::OFF_A_FLAG, r);
		chk("masked clear", r, 8'h04);
		$display("test clearing done");
		wr(pcd_pkg::OFF_IRQ_EN, 8'h10);
		wr(pcd_pkg::OFF_A_FLAG, 8'h00);
		// leftover port b flags would wake at once and hide the pin under test
		wr(pcd_pkg::OFF_B_FLAG, 8'h00);
		sleep_req <= 1'b1;
		repeat (2) @(posedge clk_i);
		a_lvl <= a_lvl ^ 8'h01;
		n = 0;
		while (woke !== 1'b1 && n < 10)
		begin
			@(posedge clk_i);
			n++;
		end
		chk("wake", {7'h0, woke}, 8'h01);
		sleep_req <= 1'b0;
		rdr(pcd_pkg::OFF_A_FLAG, q);
		chk("flag after wake", q, 8'h01);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdr(pcd_pkg::OFF_A_FLAG, q);
		chk("flag after reset", q, 8'h00);
		rdr(pcd_pkg::OFF_IRQ_EN, q);
		chk("enable after reset", q, 8'h00);
		$display("test sleep and reset done");
		report_and_stop();
	end
endmodule : tb_top
